// ---- include/tliu_cfg.svh ----
/*
 * Offsets, field positions and reset values of the three level interrupt unit.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses, one word per register.
 */
`ifndef TLIU_CFG_SVH
`define TLIU_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TLIU_OFS_TIMER_CTRL 8'h00
`define TLIU_OFS_IRQ_ENABLE 8'h04
`define TLIU_OFS_IRQ_PRIO 8'h08
`define TLIU_OFS_EXT_ENABLE 8'h0c
`define TLIU_OFS_EXT_PRIO 8'h10
`define TLIU_OFS_EXT_FLAG 8'h14
`define TLIU_OFS_EXT_CTRL 8'h18
`define TLIU_OFS_AUX_ENABLE 8'h1c
`define TLIU_OFS_AUX_STATUS 8'h20
`define TLIU_OFS_PERIPH_FLAG 8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TLIU_TC_EXT0_EDGE 0
`define TLIU_TC_EXT0_PEND 1
`define TLIU_TC_EXT1_EDGE 2
`define TLIU_TC_EXT1_PEND 3
`define TLIU_TC_TMR0_PEND 5
`define TLIU_TC_TMR1_PEND 7
`define TLIU_IE_MASTER 7
`define TLIU_XC_WDOG_PEND 3
`define TLIU_XC_AUX_PEND 4
`define TLIU_XC_AUX_EN 5
`define TLIU_XF_EXT2_PEND 4

// ----------------------------------------------------------------------------
// Reset values, vector layout and source indices
// ----------------------------------------------------------------------------
`define TLIU_RST_BYTE 8'h00
`define TLIU_RST_AUX 9'h000
`define TLIU_RST_PFLAG 5'h00
`define TLIU_VEC_BASE 8'h03
`define TLIU_IDX_AUX 4'h6
`define TLIU_IDX_EXT0 4'h0
`define TLIU_IDX_TMR0 4'h1
`define TLIU_IDX_EXT1 4'h2
`define TLIU_IDX_TMR1 4'h3

`endif

// ---- include/tliu_pkg.sv ----
/*
 * Types of the three level interrupt unit: levels, bus phases and carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tliu_pkg;

	// ------------------------------------------------------------------------
	// Priority levels, ranked so that a larger code wins.
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		TLIU_LVL_LOW = 2'b00,
		TLIU_LVL_HIGH = 2'b01,
		TLIU_LVL_AUX = 2'b10
	} tliu_level_t;

	// Phase of the register bus answer.
	typedef enum logic {
		TLIU_BUS_IDLE = 1'b0,
		TLIU_BUS_ANSWER = 1'b1
	} tliu_bus_state_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} tliu_avm_req_t;

	// Event sources; pins are active low levels, the rest are one-cycle pulses.
	typedef struct packed {
		logic [5:0] ext_pin_n;
		logic timer0_ovf;
		logic timer1_ovf;
		logic timer2_ovf;
		logic [1:0] serial_rx;
		logic [1:0] serial_tx;
		logic watchdog;
		logic [8:0] aux_evt;
	} tliu_evt_t;

	// Vector request presented to the core.
	typedef struct packed {
		logic req;
		logic [3:0] index;
		logic [7:0] vector;
		tliu_level_t level;
	} tliu_vec_t;

endpackage : tliu_pkg

// ---- hdl/tliu_arbiter.sv ----
/*
 * Combinational arbiter: picks the eligible source of highest level,
 * lowest index within a level. Assumes its caller has already gated enables.
 */
`timescale 1ns/1ps

module tliu_arbiter #(
	parameter int N = 13
) (
	input wire logic [N-1:0] i_eligible,
	input wire tliu_pkg::tliu_level_t [N-1:0] i_level,
	output logic o_found,
	output logic [3:0] o_index,
	output tliu_pkg::tliu_level_t o_level
);
	import tliu_pkg::*;

	// ------------------------------------------------------------------------
	// Selection
	// ------------------------------------------------------------------------
	// Scanning downward lets a lower index at the same level replace a higher
	// one, so the natural order decides ties inside a level.
	always_comb begin
		o_found = 1'b0;
		o_index = 4'h0;
		o_level = TLIU_LVL_LOW;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_eligible[i] && (!o_found || i_level[i] >= o_level)) begin
				o_found = 1'b1;
				o_index = 4'(i);
				o_level = i_level[i];
			end
		end
	end

endmodule : tliu_arbiter

// ---- hdl/tliu_top.sv ----
/*
 * Three level interrupt unit: pending flags, enables, priorities, the
 * auxiliary group, in-service tracking and the vector handshake to the core.
 * Assumes events arrive synchronous to i_clk and that the core pulses
 * i_vec_take when it vectors and i_reti when a service routine returns.
 */
// Operation
// - three levels: aux fixed top, others high/low.
// - each standard source: flag, enable, priority, vector.
// - nine sources share one top-level aux request.
// - aux pending bit 4, aux enable bit 5.
// - master enable bit 7 blocks all vectoring.
// - edge ext0/ext1 flags clear when vectored.
// - level ext0/ext1 flags follow pin, not cleared.
// - timer0/timer1 flags clear when vectored.
`timescale 1ns/1ps
`include "tliu_cfg.svh"

module tliu_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire tliu_pkg::tliu_avm_req_t i_avm,
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	input wire tliu_pkg::tliu_evt_t i_evt,
	input wire logic i_vec_take,
	input wire logic i_reti,
	output tliu_pkg::tliu_vec_t o_vec,
	output logic o_irq
);
	import tliu_pkg::*;

	localparam int NSRC = 13; // Vectored sources, aux group counted once.

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [7:0] tctl_reg, tctl_next; // Timer control: ext edge modes and flags.
	logic [7:0] ien_reg, ien_next; // Standard enables and master enable.
	logic [7:0] ipr_reg, ipr_next; // Standard priority bits.
	logic [4:0] xen_reg, xen_next; // Ext2-5 and watchdog enables.
	logic [4:0] xpr_reg, xpr_next; // Ext2-5 and watchdog priorities.
	logic [3:0] xfl_reg, xfl_next; // Ext2-5 pending flags.
	logic wdog_reg, wdog_next; // Watchdog pending flag.
	logic auxen_reg, auxen_next; // Auxiliary group enable.
	logic [8:0] aie_reg, aie_next; // Per-source aux enables, also the irq mask.
	logic [8:0] ast_reg, ast_next; // Sticky aux status, cleared by reading.
	logic [4:0] pfl_reg, pfl_next; // Serial rx0,tx0,rx1,tx1 and timer2 flags.
	logic [5:0] pin_reg, pin_next; // Previous pin levels for edge detection.
	logic [2:0] isv_reg, isv_next; // In-service flag per level.
	tliu_vec_t vec_reg, vec_next; // Vector request to the core.
	logic irq_reg, irq_next; // Level interrupt output.
	tliu_bus_state_t bus_reg, bus_next; // Bus answer phase.
	logic wait_reg, wait_next; // Registered waitrequest.
	logic [31:0] rd_reg, rd_next; // Registered read data.

	// ------------------------------------------------------------------------
	// Derived source view
	// ------------------------------------------------------------------------
	logic aux_pend; // Common aux pending flag.
	logic [NSRC-1:0] src_pend; // Pending per source.
	logic [NSRC-1:0] src_en; // Enable per source.
	logic [NSRC-1:0] src_hi; // High priority per source.
	logic [NSRC-1:0] eligible; // Pending, enabled and above in-service level.
	tliu_level_t [NSRC-1:0] src_lvl; // Level per source.
	logic [2:0] svc_rank; // Rank of the level now in service, 0 when none.
	logic [5:0] pin_fall; // Falling edge on each active-low pin.
	logic arb_found; // Arbiter has a winner.
	logic [3:0] arb_index; // Winning source index.
	tliu_level_t arb_level; // Winning level.

	// Aux pending is set whenever any enabled grouped source has requested.
	assign aux_pend = |(ast_reg & aie_reg);
	assign pin_fall = pin_reg & ~i_evt.ext_pin_n;
	assign src_pend = {wdog_reg, xfl_reg, pfl_reg[2] | pfl_reg[3], aux_pend,
		pfl_reg[4], pfl_reg[0] | pfl_reg[1], tctl_reg[`TLIU_TC_TMR1_PEND],
		tctl_reg[`TLIU_TC_EXT1_PEND], tctl_reg[`TLIU_TC_TMR0_PEND],
		tctl_reg[`TLIU_TC_EXT0_PEND]};
	assign src_en = {xen_reg, ien_reg[6], auxen_reg, ien_reg[5:0]};
	assign src_hi = {xpr_reg, ipr_reg[6], 1'b0, ipr_reg[5:0]};
	assign svc_rank = isv_reg[2] ? 3'd3 : isv_reg[1] ? 3'd2 : isv_reg[0] ? 3'd1 : 3'd0;

	// ------------------------------------------------------------------------
	// Per-source level and eligibility
	// ------------------------------------------------------------------------
	// Only a strictly higher level than the one in service may interrupt it.
	for (genvar g = 0; g < NSRC; g++) begin : g_src
		assign src_lvl[g] = (g == 6) ? TLIU_LVL_AUX
			: (src_hi[g] ? TLIU_LVL_HIGH : TLIU_LVL_LOW);
		assign eligible[g] = src_pend[g] & src_en[g] & ien_reg[`TLIU_IE_MASTER]
			& ({1'b0, src_lvl[g]} + 3'd1 > svc_rank);
	end

	tliu_arbiter #(
		.N(NSRC)
	) u_arb (
		.i_eligible(eligible),
		.i_level(src_lvl),
		.o_found(arb_found),
		.o_index(arb_index),
		.o_level(arb_level)
	);

	// ------------------------------------------------------------------------
	// Register bus and flag next state
	// ------------------------------------------------------------------------
	// Software writes land first, hardware clears next and hardware sets last,
	// so an event in the cycle of its clear is never lost.
	always_comb begin
		logic wr_hit;
		logic taken;
		wr_hit = (bus_reg == TLIU_BUS_ANSWER) && i_avm.write;
		taken = i_vec_take && vec_reg.req;
		tctl_next = tctl_reg;
		ien_next = ien_reg;
		ipr_next = ipr_reg;
		xen_next = xen_reg;
		xpr_next = xpr_reg;
		xfl_next = xfl_reg;
		wdog_next = wdog_reg;
		auxen_next = auxen_reg;
		aie_next = aie_reg;
		ast_next = ast_reg;
		pfl_next = pfl_reg;
		pin_next = i_evt.ext_pin_n;
		bus_next = bus_reg;
		wait_next = wait_reg;
		rd_next = rd_reg;
		// Answer phase: the write and the read clear happen at the edge at
		// which the master sees waitrequest low.
		unique case (bus_reg)
			TLIU_BUS_IDLE: begin
				wait_next = 1'b1;
				if (i_avm.read || i_avm.write) begin
					bus_next = TLIU_BUS_ANSWER;
					wait_next = 1'b0;
					rd_next = 32'h0000_0000;
					case (i_avm.address)
						`TLIU_OFS_TIMER_CTRL: rd_next[7:0] = tctl_reg;
						`TLIU_OFS_IRQ_ENABLE: rd_next[7:0] = ien_reg;
						`TLIU_OFS_IRQ_PRIO: rd_next[7:0] = {1'b0, ipr_reg[6:0]};
						`TLIU_OFS_EXT_ENABLE: rd_next[4:0] = xen_reg;
						`TLIU_OFS_EXT_PRIO: rd_next[4:0] = xpr_reg;
						`TLIU_OFS_EXT_FLAG: rd_next[7:4] = xfl_reg;
						`TLIU_OFS_EXT_CTRL: begin
							rd_next[`TLIU_XC_WDOG_PEND] = wdog_reg;
							rd_next[`TLIU_XC_AUX_PEND] = aux_pend;
							rd_next[`TLIU_XC_AUX_EN] = auxen_reg;
						end
						`TLIU_OFS_AUX_ENABLE: rd_next[8:0] = aie_reg;
						`TLIU_OFS_AUX_STATUS: rd_next[8:0] = ast_reg;
						`TLIU_OFS_PERIPH_FLAG: rd_next[4:0] = pfl_reg;
						default: rd_next = 32'h0000_0000; // Unmapped reads zero.
					endcase
				end
			end
			TLIU_BUS_ANSWER: begin
				bus_next = TLIU_BUS_IDLE;
				wait_next = 1'b1;
				// Only the bits that were shown to software are cleared.
				if (i_avm.read && i_avm.address == `TLIU_OFS_AUX_STATUS) begin
					ast_next = ast_reg & ~rd_reg[8:0];
				end
			end
		endcase
		if (wr_hit) begin
			case (i_avm.address)
				`TLIU_OFS_TIMER_CTRL: tctl_next = i_avm.writedata[7:0];
				`TLIU_OFS_IRQ_ENABLE: ien_next = i_avm.writedata[7:0];
				`TLIU_OFS_IRQ_PRIO: ipr_next = {1'b0, i_avm.writedata[6:0]};
				`TLIU_OFS_EXT_ENABLE: xen_next = i_avm.writedata[4:0];
				`TLIU_OFS_EXT_PRIO: xpr_next = i_avm.writedata[4:0];
				`TLIU_OFS_EXT_FLAG: xfl_next = i_avm.writedata[7:4];
				`TLIU_OFS_EXT_CTRL: begin
					wdog_next = i_avm.writedata[`TLIU_XC_WDOG_PEND];
					auxen_next = i_avm.writedata[`TLIU_XC_AUX_EN];
				end
				`TLIU_OFS_AUX_ENABLE: aie_next = i_avm.writedata[8:0];
				`TLIU_OFS_PERIPH_FLAG: pfl_next = i_avm.writedata[4:0];
				default: ; // Writes elsewhere are ignored.
			endcase
		end
		// Vectoring clears only edge ext0/ext1 flags and timer 0/1 flags.
		if (taken) begin
			if (vec_reg.index == `TLIU_IDX_EXT0 && tctl_reg[`TLIU_TC_EXT0_EDGE]) begin
				tctl_next[`TLIU_TC_EXT0_PEND] = 1'b0;
			end
			if (vec_reg.index == `TLIU_IDX_EXT1 && tctl_reg[`TLIU_TC_EXT1_EDGE]) begin
				tctl_next[`TLIU_TC_EXT1_PEND] = 1'b0;
			end
			if (vec_reg.index == `TLIU_IDX_TMR0) begin
				tctl_next[`TLIU_TC_TMR0_PEND] = 1'b0;
			end
			if (vec_reg.index == `TLIU_IDX_TMR1) begin
				tctl_next[`TLIU_TC_TMR1_PEND] = 1'b0;
			end
		end
		// Hardware sets; level mode makes the flag mirror the low-active pin.
		if (tctl_next[`TLIU_TC_EXT0_EDGE]) begin
			tctl_next[`TLIU_TC_EXT0_PEND] = tctl_next[`TLIU_TC_EXT0_PEND] | pin_fall[0];
		end else begin
			tctl_next[`TLIU_TC_EXT0_PEND] = ~i_evt.ext_pin_n[0];
		end
		if (tctl_next[`TLIU_TC_EXT1_EDGE]) begin
			tctl_next[`TLIU_TC_EXT1_PEND] = tctl_next[`TLIU_TC_EXT1_PEND] | pin_fall[1];
		end else begin
			tctl_next[`TLIU_TC_EXT1_PEND] = ~i_evt.ext_pin_n[1];
		end
		tctl_next[`TLIU_TC_TMR0_PEND] = tctl_next[`TLIU_TC_TMR0_PEND] | i_evt.timer0_ovf;
		tctl_next[`TLIU_TC_TMR1_PEND] = tctl_next[`TLIU_TC_TMR1_PEND] | i_evt.timer1_ovf;
		xfl_next = xfl_next | pin_fall[5:2];
		wdog_next = wdog_next | i_evt.watchdog;
		pfl_next = pfl_next | {i_evt.timer2_ovf, i_evt.serial_tx[1], i_evt.serial_rx[1],
			i_evt.serial_tx[0], i_evt.serial_rx[0]};
		ast_next = ast_next | i_evt.aux_evt;
	end

	// ------------------------------------------------------------------------
	// Vector handshake and in-service levels
	// ------------------------------------------------------------------------
	// A return releases the top level before a new take marks its own level.
	always_comb begin
		isv_next = isv_reg;
		if (i_reti) begin
			if (isv_reg[2]) begin
				isv_next[2] = 1'b0;
			end else if (isv_reg[1]) begin
				isv_next[1] = 1'b0;
			end else begin
				isv_next[0] = 1'b0;
			end
		end
		if (i_vec_take && vec_reg.req) begin
			isv_next[vec_reg.level] = 1'b1;
		end
		// The request drops for one cycle after a take so that the flag clear
		// and the new in-service level are seen before the next choice.
		vec_next.req = arb_found && !(i_vec_take && vec_reg.req);
		vec_next.index = arb_index;
		vec_next.vector = `TLIU_VEC_BASE + {1'b0, arb_index, 3'b000};
		vec_next.level = arb_level;
		irq_next = |(ast_reg & aie_reg);
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tctl_reg <= `TLIU_RST_BYTE;
			ien_reg <= `TLIU_RST_BYTE;
			ipr_reg <= `TLIU_RST_BYTE;
			xen_reg <= `TLIU_RST_PFLAG;
			xpr_reg <= `TLIU_RST_PFLAG;
			xfl_reg <= 4'h0;
			wdog_reg <= 1'b0;
			auxen_reg <= 1'b0;
			aie_reg <= `TLIU_RST_AUX;
			ast_reg <= `TLIU_RST_AUX;
			pfl_reg <= `TLIU_RST_PFLAG;
			pin_reg <= 6'h3f;
			isv_reg <= 3'h0;
			vec_reg <= '0;
			irq_reg <= 1'b0;
			bus_reg <= TLIU_BUS_IDLE;
			wait_reg <= 1'b1;
			rd_reg <= 32'h0000_0000;
		end else begin
			tctl_reg <= tctl_next;
			ien_reg <= ien_next;
			ipr_reg <= ipr_next;
			xen_reg <= xen_next;
			xpr_reg <= xpr_next;
			xfl_reg <= xfl_next;
			wdog_reg <= wdog_next;
			auxen_reg <= auxen_next;
			aie_reg <= aie_next;
			ast_reg <= ast_next;
			pfl_reg <= pfl_next;
			pin_reg <= pin_next;
			isv_reg <= isv_next;
			vec_reg <= vec_next;
			irq_reg <= irq_next;
			bus_reg <= bus_next;
			wait_reg <= wait_next;
			rd_reg <= rd_next;
		end
	end

	assign o_waitrequest = wait_reg;
	assign o_readdata = rd_reg;
	assign o_vec = vec_reg;
	assign o_irq = irq_reg;

endmodule : tliu_top

// ---- sim/tliu_top_asserts.sv ----
/* Port checker of the interrupt unit.
   Assumes it is bound into tliu_top. */
`timescale 1ns/1ps
module tliu_top_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire tliu_pkg::tliu_avm_req_t i_avm,
	input wire logic o_waitrequest,
	input wire tliu_pkg::tliu_evt_t i_evt,
	input wire logic i_vec_take,
	input wire tliu_pkg::tliu_vec_t o_vec,
	input wire logic o_irq
);
	import tliu_pkg::*;
	// ----------
	// Properties
	// ----------
	// One domain, so clock and reset are given once.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	bus_answer_a: assert property ((i_avm.read || i_avm.write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus request not answered");
	answer_once_a: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer longer than one cycle");
	answer_cause_a: assert property (!o_waitrequest |-> $past(i_avm.read || i_avm.write))
		else $error("answer without request");
	vec_addr_a: assert property (o_vec.req |-> o_vec.vector == 8'h03 + {o_vec.index, 3'b000})
		else $error("vector address wrong");
	aux_level_a: assert property (o_vec.req |-> (o_vec.index == 4'h6) == (o_vec.level == TLIU_LVL_AUX))
		else $error("aux level mismatch");
	take_drop_a: assert property (i_vec_take && o_vec.req |=> !o_vec.req)
		else $error("request kept after take");
	irq_fall_a: assert property ($fell(o_irq) |-> $past(!o_waitrequest) || $past(!o_waitrequest, 2))
		else $error("irq fell without access");
	irq_rise_a: assert property ($rose(o_irq) |-> $past(|i_evt.aux_evt, 2) || $past(i_avm.write, 2))
		else $error("irq rose without cause");
	cover property (i_vec_take && o_vec.req);
	cover property (o_vec.req && o_vec.level == TLIU_LVL_AUX);
	cover property ($fell(o_irq));
endmodule : tliu_top_asserts

bind tliu_top tliu_top_asserts u_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avm(i_avm),
	.o_waitrequest(o_waitrequest), .i_evt(i_evt), .i_vec_take(i_vec_take), .o_vec(o_vec),
	.o_irq(o_irq));

// ---- sim/tliu_core_model.sv ----
/* Core model: takes an offered vector after a set delay, returns later.
   Assumes tliu_top drives i_vec. */
`timescale 1ns/1ps
module tliu_core_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire tliu_pkg::tliu_vec_t i_vec,
	input wire logic i_take_en,
	input wire logic [3:0] i_delay,
	output logic o_take,
	output logic o_reti,
	output logic [7:0] o_vector,
	output logic [7:0] o_takes
);
	import tliu_pkg::*;
	logic [3:0] wait_reg; // Cycles the offer has stood.
	logic [3:0] svc_reg; // Cycles left in the routine.
	// One routine at a time; nesting is not modelled, which is a limitation.
	// o_take and o_reti are assigned on every branch; o_vector and o_takes only at reset and on a take.
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_take <= 1'b0;
			o_reti <= 1'b0;
			wait_reg <= 4'h0;
			svc_reg <= 4'h0;
			o_vector <= 8'h00;
			o_takes <= 8'h00;
		end else if (svc_reg != 4'h0) begin
			o_take <= 1'b0;
			svc_reg <= svc_reg - 4'h1;
			o_reti <= (svc_reg == 4'h1);
		end else if (i_take_en && i_vec.req) begin
			o_reti <= 1'b0;
			o_take <= (wait_reg >= i_delay);
			if (wait_reg >= i_delay) begin
				o_vector <= i_vec.vector;
				o_takes <= o_takes + 8'h01;
				wait_reg <= 4'h0;
				svc_reg <= 4'h7;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end else begin
			o_take <= 1'b0;
			o_reti <= 1'b0;
			wait_reg <= 4'h0;
		end
	end
endmodule : tliu_core_model

// ---- sim/three_level_interrupt_unit_test.sv ----
/* Self-checking bench of the interrupt unit.
   Assumes tliu_top, its checker and the core model. */
`timescale 1ns/1ps
module three_level_interrupt_unit_test;
	import tliu_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	tliu_avm_req_t avm = '0;
	tliu_evt_t evt = '{ext_pin_n: 6'h3f, default: '0}; // Pins idle high.
	tliu_vec_t vec;
	logic waitreq, irq, take, reti;
	logic take_en = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [31:0] rdata, bus_q;
	logic [7:0] last_vec, takes;
	int fail_count = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	tliu_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_avm(avm), .o_waitrequest(waitreq),
		.o_readdata(rdata), .i_evt(evt), .i_vec_take(take), .i_reti(reti), .o_vec(vec), .o_irq(irq));
	tliu_core_model core (.i_clk(clk), .i_rst_n(rst_n), .i_vec(vec), .i_take_en(take_en),
		.i_delay(delay), .o_take(take), .o_reti(reti), .o_vector(last_vec), .o_takes(takes));
	// ----------
	// Helpers
	// ----------
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Holds the request until waitrequest is seen low, then releases it.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avm <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (n >= 20) begin
			fail_count++;
			test_done();
		end
		bus_q = rdata;
		avm <= '0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(bus_q, exp);
	endtask : rd
	task automatic pulse(input tliu_evt_t p);
		evt <= evt | p;
		@(posedge clk);
		evt <= evt & ~p;
		@(posedge clk);
	endtask : pulse
	task automatic wait_take;
		logic [7:0] t0;
		int n;
		t0 = takes;
		n = 0;
		while (takes === t0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40) begin
			fail_count++;
			test_done();
		end
	endtask : wait_take
	// ----------
	// Scenarios
	// ----------
	task automatic s_reset_values;
		for (int k = 0; k < 10; k++) rd(8'(k * 4), 32'h0);
		bus(1'b1, 8'h30, 32'hff);
		rd(8'h30, 32'h0);
	endtask : s_reset_values
	// Each standard source alone: own flag, enable and vector.
	task automatic s_vector_table;
		logic [7:0] pa[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h24, 8'h24, 8'h24, 8'h14, 8'h14,
			8'h14, 8'h14, 8'h18};
		logic [7:0] pv[12] = '{8'h03, 8'h20, 8'h0c, 8'h80, 8'h01, 8'h10, 8'h04, 8'h10, 8'h20,
			8'h40, 8'h80, 8'h08};
		logic [3:0] ix[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha,
			4'hb, 4'hc};
		logic [7:0] ea, ev, mb;
		bus(1'b1, 8'h04, 32'h80);
		for (int i = 0; i < 12; i++) begin
			ea = (i < 7) ? 8'h04 : 8'h0c;
			mb = (i < 7) ? 8'h80 : 8'h00;
			ev = 8'h01 << ((i < 7) ? i : i - 7);
			bus(1'b1, ea, {24'h0, ev | mb});
			bus(1'b1, pa[i], {24'h0, pv[i]});
			repeat (2) @(posedge clk);
			check({17'h0, vec.req, vec.index, vec.vector, vec.level},
				{17'h0, 1'b1, ix[i], 8'h03 + {ix[i], 3'b000}, TLIU_LVL_LOW});
			bus(1'b1, pa[i], 32'h0);
			bus(1'b1, ea, {24'h0, mb});
		end
		bus(1'b1, 8'h04, 32'h0);
	endtask : s_vector_table
	task automatic s_timer_clear;
		bus(1'b1, 8'h04, 32'h02);
		pulse(tliu_evt_t'{timer0_ovf: 1'b1, default: '0});
		repeat (3) @(posedge clk);
		check({31'h0, vec.req}, 32'h0);
		take_en <= 1'b1;
		bus(1'b1, 8'h04, 32'h82);
		wait_take();
		check({24'h0, last_vec}, 32'h0b);
		rd(8'h00, 32'h0);
		delay <= 4'h5;
		bus(1'b1, 8'h04, 32'h88);
		pulse(tliu_evt_t'{timer1_ovf: 1'b1, default: '0});
		wait_take();
		check({24'h0, last_vec}, 32'h1b);
		rd(8'h00, 32'h0);
		delay <= 4'h0;
		bus(1'b1, 8'h04, 32'h0);
	endtask : s_timer_clear
	task automatic s_ext0_modes;
		bus(1'b1, 8'h00, 32'h01);
		bus(1'b1, 8'h04, 32'h81);
		evt.ext_pin_n[0] <= 1'b0;
		wait_take();
		check({24'h0, last_vec}, 32'h03);
		rd(8'h00, 32'h01);
		take_en <= 1'b0;
		bus(1'b1, 8'h00, 32'h0);
		repeat (2) @(posedge clk);
		rd(8'h00, 32'h02);
		evt.ext_pin_n[0] <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h00, 32'h0);
		bus(1'b1, 8'h04, 32'h0);
	endtask : s_ext0_modes
	// Timer 1 high beats ext0 low; the aux group beats both.
	task automatic s_priority_aux;
		bus(1'b1, 8'h08, 32'h08);
		bus(1'b1, 8'h04, 32'h89);
		bus(1'b1, 8'h00, 32'h83);
		// The new choice is registered one edge after the write lands.
		@(posedge clk);
		check({22'h0, vec.level, vec.vector}, {22'h0, TLIU_LVL_HIGH, 8'h1b});
		bus(1'b1, 8'h1c, 32'h1ff);
		pulse(tliu_evt_t'{aux_evt: 9'h100, default: '0});
		@(posedge clk);
		check({31'h0, vec.vector == 8'h1b}, 32'h1);
		bus(1'b1, 8'h18, 32'h20);
		// Same lag: the group enable reaches the vector one edge later.
		@(posedge clk);
		check({21'h0, irq, vec.level, vec.vector}, {21'h0, 1'b1, TLIU_LVL_AUX, 8'h33});
		rd(8'h18, 32'h30);
		rd(8'h20, 32'h100);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd(8'h18, 32'h20);
		for (int k = 0; k < 8; k++) bus(1'b1, 8'(k * 4), 32'h0);
	endtask : s_priority_aux
	task automatic s_soft_flags;
		take_en <= 1'b1;
		bus(1'b1, 8'h04, 32'h90);
		pulse(tliu_evt_t'{serial_rx: 2'b01, default: '0});
		wait_take();
		check({24'h0, last_vec}, 32'h23);
		bus(1'b1, 8'h04, 32'h0);
		rd(8'h24, 32'h01);
		bus(1'b1, 8'h24, 32'h0);
		bus(1'b1, 8'h0c, 32'h10);
		bus(1'b1, 8'h04, 32'h80);
		pulse(tliu_evt_t'{watchdog: 1'b1, default: '0});
		wait_take();
		check({24'h0, last_vec}, 32'h63);
		bus(1'b1, 8'h04, 32'h0);
		rd(8'h18, 32'h08);
		take_en <= 1'b0;
	endtask : s_soft_flags
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		s_reset_values();
		s_vector_table();
		s_timer_clear();
		s_ext0_modes();
		s_priority_aux();
		s_soft_flags();
		test_done();
	end
endmodule : three_level_interrupt_unit_test
